// file: core/sprd_mem.sv
// Byte-wide memory model of 2^DEPTH_W bytes, sized by parameter; the rest of the pointer space aliases onto it.
// Assumes requests are single-cycle pulses; answers one cycle later.
module sprd_mem #(
  parameter int DEPTH_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  sprd_mem_if.memory mem
);
  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } sprd_mem_st_t;
  logic [7:0] store [0:(1<<DEPTH_W)-1];
  sprd_mem_st_t st_reg;
  sprd_mem_st_t st_next;

  // Only the low address bits index the array; upper bits alias
  always_comb begin
    st_next = st_reg;
    st_next.ack = mem.req;
    if (mem.req) begin
      st_next.data = store[mem.addr[DEPTH_W-1:0]];
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Contents are erased-state until the bench preloads them hierarchically
  initial begin
    for (int i = 0; i < (1<<DEPTH_W); i++) begin
      store[i] = 8'hff;
    end
  end

  assign mem.ack = st_reg.ack;
  assign mem.data = st_reg.data;
endmodule

// file: core/sprd_mem_if.sv
// Read request/answer pair between the serial engine and the memory.
// Assumes the memory answers in a fixed number of system clocks.
interface sprd_mem_if;
  logic req;
  logic [sprd_pkg::ADDR_W-1:0] addr;
  logic ack;
  logic [7:0] data;
  modport engine (output req, output addr, input ack, input data);
  modport memory (input req, input addr, output ack, output data);
endinterface

// file: core/sprd_pkg.sv
// Shared constants for the serial program memory read block.
// Assumes a single system clock domain; the programming clock is sampled.
package sprd_pkg;
  localparam int ADDR_W = 22;
  localparam int CMD_W = 4;
  localparam int OPND_W = 16;
  localparam int HALF_W = 8;
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_TABLE_READ_POSTINC_POSTINC = 4'h9;
  localparam logic [7:0] OP_LOAD_LITERAL = 8'h0e;
  localparam logic [7:0] OP_MOVE_TO_FILE = 8'h6e;
  localparam logic [7:0] FILE_PTR_UPPER = 8'hf8;
  localparam logic [7:0] FILE_PTR_HIGH = 8'hf7;
  localparam logic [7:0] FILE_PTR_LOW = 8'hf6;
  localparam logic [5:0] UPPER_MASK = 6'h3f;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [21:0] ADDR_INC = 22'h000001;
  localparam logic [21:0] ADDR_RESET = 22'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int MEM_LATENCY = 1;
endpackage

// file: core/sprd_top.sv
// Serial programming port read path: command shifter, pointer, byte output.
// Assumes the programmer drives prog_clock_pin and honours the turnaround delay.
module sprd_top #(
  parameter int DEPTH_W = 12
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic prog_clock_pin_i,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe_o,
  output logic [sprd_pkg::ADDR_W-1:0] table_pointer_o
);
  // Frame layout as seen from behind the pins:
  //   4 command bits and then 16 operand bits, every bit taken on a falling
  //   link clock once both pins have passed their synchronisers.
  //   For a read the fetch is requested as the command completes, and the byte
  //   is back long before the 8th operand fall. The pin turns to output in the
  //   clock-low wait after that fall and shows one new bit after each fall.
  // Both pins are sampled by the system clock, so every link phase must last
  // several system clocks; a faster link clock would lose edges unseen.
  // The operand input keeps shifting during the output half and then sees our
  // own drive. That is harmless because only core instructions decode it.
  // The pointer steps only after the fetch has taken the old address.

  typedef enum logic [1:0] {
    SPRD_CMD = 2'b00,
    SPRD_OPND_LO = 2'b01,
    SPRD_OPND_HI = 2'b11
  } sprd_phase_t;

  // All state in one record; the two sync fields are the pin synchronisers,
  // and clk_prev is the third stage that the edge detector compares against
  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_prev;
    sprd_phase_t phase;
    logic [4:0] cnt;
    logic [3:0] cmd;
    logic [15:0] opnd;
    logic [7:0] work;
    logic [5:0] ptr_u;
    logic [7:0] ptr_h;
    logic [7:0] ptr_l;
    logic [7:0] rd_byte;
    logic req;
    logic dout;
    logic oe;
  } sprd_st_t;

  sprd_st_t st_reg;
  sprd_st_t st_next;
  sprd_mem_if mem_bus ();

  logic clk_s;
  logic dat_s;
  logic rise;
  logic fall;
  logic is_read;
  // Decoded views of the state, shared by the next-state logic below
  logic is_core;
  logic [sprd_pkg::CMD_W-1:0] cmd_full;
  logic cmd_done;
  logic [sprd_pkg::OPND_W-1:0] opnd_full;
  logic [7:0] op_code;
  logic [7:0] op_arg;
  logic [sprd_pkg::ADDR_W-1:0] ptr_cur;
  logic [sprd_pkg::ADDR_W-1:0] ptr_inc;
  logic [2:0] bit_idx;

  // Second stage only; first stage feeds nothing but the second
  assign clk_s = st_reg.clk_sync[1];
  assign dat_s = st_reg.dat_sync[1];
  assign rise = clk_s & ~st_reg.clk_prev;
  assign fall = ~clk_s & st_reg.clk_prev;
  assign is_read = (st_reg.cmd == sprd_pkg::CMD_TABLE_READ_POSTINC_POSTINC);
  assign is_core = (st_reg.cmd == sprd_pkg::CMD_CORE);

  // Command as it will stand once the bit of the current fall is shifted in
  assign cmd_full = {dat_s, st_reg.cmd[3:1]};
  assign cmd_done = (st_reg.cnt == 5'(sprd_pkg::CMD_W - 1));

  // Whole operand once its last bit is in; the low byte arrives first, so the
  // opcode lands in the high byte and the literal or file address in the low
  assign opnd_full = {dat_s, st_reg.opnd[15:1]};
  assign op_code = opnd_full[15:8];
  assign op_arg = opnd_full[7:0];

  // Joined pointer and its successor; the carry runs through all 22 bits,
  // so stepping past the top of the space wraps to zero
  assign ptr_cur = {st_reg.ptr_u, st_reg.ptr_h, st_reg.ptr_l};
  assign ptr_inc = ptr_cur + sprd_pkg::ADDR_INC;

  // Bit shown after the next fall; wraps to bit 0 after bit 7, which is
  // harmless because the pin is released on that same fall
  assign bit_idx = 3'(st_reg.cnt + sprd_pkg::CNT_ONE);

  always_comb begin
    st_next = st_reg;
    st_next.clk_sync = {st_reg.clk_sync[0], prog_clock_pin_i};
    st_next.dat_sync = {st_reg.dat_sync[0], prog_data_pin_i};
    st_next.clk_prev = clk_s;
    st_next.req = 1'b0;
    // Memory answer lands well inside the first operand half
    if (mem_bus.ack) begin
      st_next.rd_byte = mem_bus.data;
    end
    // Pointer steps in the cycle after the fetch request, once the memory has
    // taken the old address; stepping with the request would fetch the byte
    // after the one that the pointer named
    if (st_reg.req) begin
      {st_next.ptr_u, st_next.ptr_h, st_next.ptr_l} = ptr_inc;
    end
    unique case (st_reg.phase)
      SPRD_CMD: begin
        // Input bits are taken on the falling clock edge
        if (fall) begin
          st_next.cmd = cmd_full;
          st_next.cnt = st_reg.cnt + sprd_pkg::CNT_ONE;
          if (cmd_done) begin
            st_next.cnt = sprd_pkg::CNT_ZERO;
            st_next.phase = SPRD_OPND_LO;
            // One fetch per read command, issued as the command completes;
            // the pointer follows a cycle later, behind the fetch
            if (cmd_full == sprd_pkg::CMD_TABLE_READ_POSTINC_POSTINC) begin
              st_next.req = 1'b1;
            end
          end
        end
      end
      SPRD_OPND_LO: begin
        if (fall) begin
          st_next.opnd = {dat_s, st_reg.opnd[15:1]};
          st_next.cnt = st_reg.cnt + sprd_pkg::CNT_ONE;
          if (st_reg.cnt == 5'(sprd_pkg::HALF_W - 1)) begin
            st_next.cnt = sprd_pkg::CNT_ZERO;
            st_next.phase = SPRD_OPND_HI;
            // Turn pin during the clock-low turnaround after the 8th fall
            if (is_read) begin
              st_next.oe = 1'b1;
              st_next.dout = st_reg.rd_byte[0];
            end
          end
        end
      end
      SPRD_OPND_HI: begin
        if (fall) begin
          st_next.opnd = {dat_s, st_reg.opnd[15:1]};
          st_next.cnt = st_reg.cnt + sprd_pkg::CNT_ONE;
          if (is_read) begin
            // Next bit presented after each falling edge, LSb to MSb
            st_next.dout = st_reg.rd_byte[bit_idx];
          end
          if (st_reg.cnt == 5'(sprd_pkg::HALF_W - 1)) begin
            st_next.cnt = sprd_pkg::CNT_ZERO;
            st_next.phase = SPRD_CMD;
            st_next.oe = 1'b0;
            st_next.dout = 1'b0;
            // Core instruction: literal load or move to a pointer byte
            if (is_core) begin
              if (op_code == sprd_pkg::OP_LOAD_LITERAL) begin
                st_next.work = op_arg;
              end else if (op_code == sprd_pkg::OP_MOVE_TO_FILE) begin
                // Low byte arrived first and names the pointer byte to load
                unique case (op_arg)
                  sprd_pkg::FILE_PTR_UPPER: st_next.ptr_u = st_reg.work[5:0];
                  sprd_pkg::FILE_PTR_HIGH: st_next.ptr_h = st_reg.work;
                  sprd_pkg::FILE_PTR_LOW: st_next.ptr_l = st_reg.work;
                  default: st_next.ptr_l = st_reg.ptr_l;
                endcase
              end
            end
          end
        end
      end
      default: begin
        st_next.phase = SPRD_CMD;
        st_next.cnt = sprd_pkg::CNT_ZERO;
        st_next.oe = 1'b0;
      end
    endcase
  end

  // Whole state in one register; reset loads only constants
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
      st_reg.phase <= SPRD_CMD;
    end else begin
      st_reg <= st_next;
    end
  end

  // Read address is the joined pointer bytes
  assign mem_bus.req = st_reg.req;
  assign mem_bus.addr = ptr_cur;

  sprd_mem #(
    .DEPTH_W(DEPTH_W)
  ) u_mem (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .mem(mem_bus)
  );

  assign prog_data_pin_o = st_reg.dout;
  assign prog_data_pin_oe_o = st_reg.oe;
  assign table_pointer_o = ptr_cur;
endmodule

// file: testbench/sprd_monitor.sv
// Checker for the serial read path, bound to the top module.
// Assumes each link clock phase lasts at least 4 system clocks.
module sprd_monitor (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic prog_clock_pin_i,
  input wire logic prog_data_pin_o,
  input wire logic prog_data_pin_oe_o,
  input wire logic [sprd_pkg::ADDR_W-1:0] table_pointer_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] prev_reg;
  logic [3:0] fall_reg;
  logic clk_reg;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Last pointer, and link falls counted while the pin is driven
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_reg <= 22'h000000;
      fall_reg <= 4'h0;
      clk_reg <= 1'h0;
    end else begin
      prev_reg <= table_pointer_o;
      clk_reg <= prog_clock_pin_i;
      fall_reg <= !prog_data_pin_oe_o ? 4'h0 : fall_reg + 4'((clk_reg && !prog_clock_pin_i) ? 1 : 0);
    end
  end
  oe_rise_low_a: assert property ($rose(prog_data_pin_oe_o) |-> !prog_clock_pin_i)
    else $error("pin turned while link clock high");
  turn_delay_a: assert property ($rose(prog_data_pin_oe_o) |-> !$past(prog_clock_pin_i, 2))
    else $error("pin turned too soon after a fall");
  bit_hold_a: assert property (prog_data_pin_oe_o && prog_clock_pin_i && $past(prog_clock_pin_i)
    && $past(prog_clock_pin_i, 2) |-> $stable(prog_data_pin_o))
    else $error("output bit moved while clock high");
  ptr_hold_a: assert property (prog_data_pin_oe_o && $past(prog_data_pin_oe_o) |-> $stable(table_pointer_o))
    else $error("pointer moved during output");
  oe_span_a: assert property ($rose(prog_data_pin_oe_o) |-> prog_data_pin_oe_o [*8])
    else $error("output phase cut short");
  oe_release_a: assert property ($rose(prog_data_pin_oe_o) |-> ##[1:400] !prog_data_pin_oe_o)
    else $error("pin not released");
  read_len_a: assert property ($fell(prog_data_pin_oe_o) |-> fall_reg == 4'h8)
    else $error("output phase not eight bits");
  ptr_step_a: assert property (table_pointer_o != prev_reg |-> table_pointer_o == prev_reg + 22'h000001
    || table_pointer_o[21:8] == prev_reg[21:8] || table_pointer_o[15:0] == prev_reg[15:0]
    || {table_pointer_o[21:16], table_pointer_o[7:0]} == {prev_reg[21:16], prev_reg[7:0]})
    else $error("pointer jumped");
endmodule
bind sprd_top sprd_monitor u_sprd_monitor (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
  .prog_clock_pin_i(prog_clock_pin_i), .prog_data_pin_o(prog_data_pin_o),
  .prog_data_pin_oe_o(prog_data_pin_oe_o), .table_pointer_o(table_pointer_o));

// file: testbench/sprd_prog.sv
// Programmer model: makes the link clock, shifts data, releases the pin to read.
// Assumes the device samples data on falling link clock edges.
module sprd_prog #(
  // Extra system clocks of clock-low wait after the 8th operand fall; a plain
  // default, long enough for the device to turn its pin
  parameter int TURN_CYCLES = 6
) (
  input wire logic sys_clk_i,
  input wire logic pin_i,
  output logic clk_o,
  output logic dat_o,
  output logic en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands low and the pin is driven between frames
  initial begin
    clk_o = 1'h0;
    dat_o = 1'h0;
    en_o = 1'h1;
  end
  // LSb first, 4 system clocks per phase, data moves only with the rising edge
  task automatic shift(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      clk_o <= 1'h1;
      dat_o <= v[i];
      repeat (4) @(posedge sys_clk_i);
      clk_o <= 1'h0;
      repeat (3) @(posedge sys_clk_i);
    end
  endtask
  task automatic core(input logic [15:0] w);
    shift({12'h000, sprd_pkg::CMD_CORE}, 4);
    shift(w, 16);
    // One more edge so the instruction has landed before anyone looks
    @(posedge sys_clk_i);
  endtask
  // Release at once; the long low wait covers the turnaround
  task automatic read(output logic [7:0] b);
    shift({12'h000, sprd_pkg::CMD_TABLE_READ_POSTINC_POSTINC}, 4);
    shift(16'h0000, 8);
    en_o <= 1'h0;
    repeat (TURN_CYCLES) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      clk_o <= 1'h1;
      repeat (3) @(posedge sys_clk_i);
      b[i] = pin_i;
      @(posedge sys_clk_i);
      clk_o <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
    end
    en_o <= 1'h1;
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench: programmer model on the pins, memory preloaded by name.
// Assumes the top holds its memory as u_mem with array store.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic pclk, pdat, pen, dout, oe, pin;
  logic [21:0] ptr;
  logic [7:0] b;
  int bad_count = 0;
  int checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  // Device drive wins, then the programmer, else the pull-up
  assign pin = oe ? dout : (pen ? pdat : 1'h1);
  sprd_top u_sprd_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .prog_clock_pin_i(pclk),
    .prog_data_pin_i(pin), .prog_data_pin_o(dout), .prog_data_pin_oe_o(oe), .table_pointer_o(ptr));
  sprd_prog u_sprd_prog (.sys_clk_i(sys_clk_i), .pin_i(pin), .clk_o(pclk), .dat_o(pdat), .en_o(pen));
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bounded wait for the pin release after a read
  task automatic read_byte(input logic [7:0] exp);
    int n;
    n = 0;
    u_sprd_prog.read(b);
    check({14'h0000, b}, {14'h0000, exp});
    while (oe !== 1'h0 && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    check({21'h000000, oe}, 22'h000000);
    if (n == 40) begin
      end_of_test();
    end
  endtask
  task automatic set_ptr(input logic [21:0] a);
    u_sprd_prog.core({sprd_pkg::OP_LOAD_LITERAL, 2'h0, a[21:16]});
    u_sprd_prog.core({sprd_pkg::OP_MOVE_TO_FILE, sprd_pkg::FILE_PTR_UPPER});
    u_sprd_prog.core({sprd_pkg::OP_LOAD_LITERAL, a[15:8]});
    u_sprd_prog.core({sprd_pkg::OP_MOVE_TO_FILE, sprd_pkg::FILE_PTR_HIGH});
    u_sprd_prog.core({sprd_pkg::OP_LOAD_LITERAL, a[7:0]});
    u_sprd_prog.core({sprd_pkg::OP_MOVE_TO_FILE, sprd_pkg::FILE_PTR_LOW});
    check(ptr, a);
  endtask
  // Two back-to-back reads return neighbouring bytes
  task automatic test_read_pair();
    set_ptr(22'h012345);
    read_byte(8'h5a);
    check(ptr, 22'h012346);
    read_byte(8'hc3);
    check(ptr, 22'h012347);
    $display("test_read_pair done");
  endtask
  // A first read thrown away, then repeated from the same address
  task automatic test_discard_read();
    set_ptr(22'h012346);
    u_sprd_prog.read(b);
    set_ptr(22'h012346);
    read_byte(8'hc3);
    check(ptr, 22'h012347);
    $display("test_discard_read done");
  endtask
  // Top of the address space, then the pointer wraps
  task automatic test_top_addr();
    set_ptr(22'h3fffff);
    read_byte(8'h81);
    check(ptr, 22'h000000);
    $display("test_top_addr done");
  endtask
  // Foreign core words and an unknown command leave the pointer alone
  task automatic test_ignored();
    u_sprd_prog.core(16'h6e00);
    u_sprd_prog.core(16'h0e77);
    check(ptr, 22'h000000);
    u_sprd_prog.shift(16'h0005, 4);
    u_sprd_prog.shift(16'h0000, 16);
    check({oe, ptr[20:0]}, 22'h000000);
    u_sprd_prog.core({sprd_pkg::OP_MOVE_TO_FILE, sprd_pkg::FILE_PTR_LOW});
    check(ptr, 22'h000077);
    $display("test_ignored done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'h0;
    repeat (4) @(posedge sys_clk_i);
    u_sprd_top.u_mem.store[12'h345] = 8'h5a;
    u_sprd_top.u_mem.store[12'h346] = 8'hc3;
    u_sprd_top.u_mem.store[12'hfff] = 8'h81;
    test_read_pair();
    test_discard_read();
    test_top_addr();
    test_ignored();
    end_of_test();
  end
endmodule
